// File: verilog/bdm_data_memory.sv
// banked data memory: decoder, general ram, status and pointer
// assumes the core presents one file access per cycle, inputs synchronous to clk
// peripheral registers live elsewhere and answer over the sfr strobe port
// Function
// - bank_select_bit clear routes direct file accesses to bank 0, set routes them to bank 1; indirect ones follow pointer bit 7.
// - the low 32 addresses of each bank decode to special function registers, not ram.
// - bank 0 addresses 20h to 7Fh are general ram on every variant.
// - on the large variant bank 1 addresses A0h to BFh are a separate general ram.
// - bank 1 addresses F0h to FFh reach the same cells as bank 0 70h to 7Fh.
// - general ram holds 96 bytes on small variants and 128 bytes on the large one.
// - every location is reachable directly or through the indirect pointer.
// - address 00h and 80h are the indirect data port with no storage of their own.
// - option, port direction, power, eeprom and voltage reference sit only in bank 1.
`timescale 1ns/1ps
module bdm_data_memory
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic large_variant,
  input wire logic [6:0] file_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic status_flags_we,
  input wire logic [7:0] status_flags_in,
  output logic [7:0] status_word,
  output logic [7:0] pointer_word,
  output logic bank_select_bit,
  output logic [4:0] sfr_sel,
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_wr_data,
  input wire logic [7:0] sfr_rd_data
);

  // ----------------------------------------
  // reset
  // ----------------------------------------
  logic rst_n;

  bdm_reset_sync u_reset_sync (
    .clk(clk),
    .resetn(resetn),
    .rst_sync_n(rst_n)
  );

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  logic direct_is_indirect;
  logic eff_bank;
  logic [6:0] eff_offset;
  bdm_target_t target;
  logic [6:0] ram_index;

  always_comb begin
    direct_is_indirect = (file_addr == BDM_OFS_INDIRECT);
    if (direct_is_indirect) begin
      eff_bank = pointer_word[7];
      eff_offset = pointer_word[6:0];
    end else begin
      eff_bank = status_word[BDM_BANK_SELECT_POS];
      eff_offset = file_addr;
    end
  end

  bdm_addr_decode u_decode (
    .bank(eff_bank),
    .offset(eff_offset),
    .large_variant(large_variant),
    .target(target),
    .ram_index(ram_index)
  );

  logic port_loop;

  always_comb begin
    // pointer aimed at the port itself reaches no storage
    port_loop = direct_is_indirect && (eff_offset == BDM_OFS_INDIRECT);
  end

  // ----------------------------------------
  // general ram arrays
  // ----------------------------------------
  logic [7:0] ram0 [0:BDM_B0_RAM_WORDS-1];
  logic [7:0] ram1 [0:BDM_B1_RAM_WORDS-1];
  logic ram0_we;
  logic ram1_we;

  always_comb begin
    ram0_we = wr_en && !port_loop && (target == BDM_T_RAM0);
    ram1_we = wr_en && !port_loop && (target == BDM_T_RAM1);
  end

  always_ff @(posedge clk) begin
    if (ram0_we) begin
      ram0[ram_index] <= wr_data;
    end
    if (ram1_we) begin
      ram1[ram_index[4:0]] <= wr_data;
    end
  end

  // ----------------------------------------
  // status and pointer registers
  // ----------------------------------------
  logic [7:0] next_status_word;
  logic [7:0] next_pointer_word;

  always_comb begin
    next_status_word = status_word;
    next_pointer_word = pointer_word;
    if (status_flags_we) begin
      next_status_word = status_flags_in;
    end
    if (wr_en && !port_loop && target == BDM_T_STATUS) begin
      next_status_word = wr_data;
    end
    if (wr_en && !port_loop && target == BDM_T_POINTER) begin
      next_pointer_word = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word <= BDM_STATUS_RESET;
      pointer_word <= BDM_POINTER_RESET;
    end else begin
      status_word <= next_status_word;
      pointer_word <= next_pointer_word;
    end
  end

  assign bank_select_bit = status_word[BDM_BANK_SELECT_POS];

  // ----------------------------------------
  // strobes to peripheral registers
  // ----------------------------------------
  logic sfr_hit;

  always_comb begin
    case (target)
      BDM_T_NONE, BDM_T_RAM0, BDM_T_RAM1, BDM_T_STATUS, BDM_T_POINTER: sfr_hit = 1'b0;
      default: sfr_hit = !port_loop;
    endcase
  end

  assign sfr_sel = target;
  assign sfr_rd = rd_en && sfr_hit;
  assign sfr_wr = wr_en && sfr_hit;
  assign sfr_wr_data = wr_data;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en && !port_loop) begin
      case (target)
        BDM_T_RAM0: next_rd_data = ram0[ram_index];
        BDM_T_RAM1: next_rd_data = ram1[ram_index[4:0]];
        BDM_T_STATUS: next_rd_data = status_word;
        BDM_T_POINTER: next_rd_data = pointer_word;
        BDM_T_NONE: next_rd_data = 8'h00;
        default: next_rd_data = sfr_rd_data;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// File: shared/bdm_pkg.sv
// package for the banked data memory decoder
// assumes a single 100 MHz clock domain and an 8-bit file bus
package bdm_pkg;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [6:0] BDM_OFS_INDIRECT = 7'h00;
  localparam logic [6:0] BDM_OFS_TIMER0_OPT = 7'h01;
  localparam logic [6:0] BDM_OFS_PCL = 7'h02;
  localparam logic [6:0] BDM_OFS_STATUS = 7'h03;
  localparam logic [6:0] BDM_OFS_POINTER = 7'h04;
  localparam logic [6:0] BDM_OFS_PORTA = 7'h05;
  localparam logic [6:0] BDM_OFS_PORTB = 7'h06;
  localparam logic [6:0] BDM_OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] BDM_OFS_INTCTL = 7'h0B;
  localparam logic [6:0] BDM_OFS_PIR_PIE = 7'h0C;
  localparam logic [6:0] BDM_OFS_PWRCTL = 7'h0E;
  localparam logic [6:0] BDM_OFS_EEPROM = 7'h10;
  localparam logic [6:0] BDM_OFS_CMP_VREF = 7'h1F;
  localparam logic [6:0] BDM_SFR_LIMIT = 7'h20;
  localparam logic [6:0] BDM_B1_RAM_LAST = 7'h3F;
  localparam logic [6:0] BDM_COMMON_FIRST = 7'h70;
  localparam int BDM_BANK_SELECT_POS = 5;

  // ----------------------------------------
  // storage sizes and reset values
  // ----------------------------------------
  localparam int BDM_B0_RAM_WORDS = 96;
  localparam int BDM_B1_RAM_WORDS = 32;
  localparam logic [7:0] BDM_STATUS_RESET = 8'h18;
  localparam logic [7:0] BDM_POINTER_RESET = 8'h00;
  localparam int BDM_SYNC_STAGES = 2;

  // ----------------------------------------
  // decoded target of one access
  // ----------------------------------------
  typedef enum logic [4:0] {
    BDM_T_NONE, BDM_T_RAM0, BDM_T_RAM1, BDM_T_STATUS, BDM_T_POINTER,
    BDM_T_PCL, BDM_T_PROGRAM_COUNTER_HIGH_LATCH, BDM_T_INTCTL, BDM_T_TIMER0, BDM_T_OPTION,
    BDM_T_PORTA, BDM_T_PORTB, BDM_T_PORTA_DIR, BDM_T_PORTB_DIR,
    BDM_T_PIR, BDM_T_PIE, BDM_T_PWRCTL, BDM_T_EEPROM, BDM_T_CMP, BDM_T_VREF
  } bdm_target_t;

endpackage

// File: verilog/bdm_reset_sync.sv
// reset release synchroniser
// assumes resetn is asynchronous and active low
`timescale 1ns/1ps
module bdm_reset_sync
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  output logic rst_sync_n
);

  logic [BDM_SYNC_STAGES-1:0] stages;
  logic [BDM_SYNC_STAGES-1:0] next_stages;

  always_comb begin
    next_stages = {stages[BDM_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stages <= '0;
    end else begin
      stages <= next_stages;
    end
  end

  assign rst_sync_n = stages[BDM_SYNC_STAGES-1];

endmodule

// File: verilog/bdm_addr_decode.sv
// combinational file address decoder
// assumes a 7-bit bank offset plus the bank select bit
`timescale 1ns/1ps
module bdm_addr_decode
  import bdm_pkg::*;
(
  input wire logic bank,
  input wire logic [6:0] offset,
  input wire logic large_variant,
  output bdm_target_t target,
  output logic [6:0] ram_index
);

  always_comb begin
    target = BDM_T_NONE;
    ram_index = 7'h00;
    if (offset >= BDM_SFR_LIMIT) begin
      // ----------------------------------------
      // general purpose ram
      // ----------------------------------------
      if (!bank) begin
        target = BDM_T_RAM0;
        ram_index = offset - BDM_SFR_LIMIT;
      end else if (offset >= BDM_COMMON_FIRST) begin
        target = BDM_T_RAM0;
        ram_index = offset - BDM_SFR_LIMIT;
      end else if (large_variant && offset <= BDM_B1_RAM_LAST) begin
        target = BDM_T_RAM1;
        ram_index = offset - BDM_SFR_LIMIT;
      end
    end else begin
      // ----------------------------------------
      // special function registers
      // ----------------------------------------
      case (offset)
        BDM_OFS_PCL: target = BDM_T_PCL;
        BDM_OFS_STATUS: target = BDM_T_STATUS;
        BDM_OFS_POINTER: target = BDM_T_POINTER;
        BDM_OFS_PROGRAM_COUNTER_HIGH_LATCH: target = BDM_T_PROGRAM_COUNTER_HIGH_LATCH;
        BDM_OFS_INTCTL: target = BDM_T_INTCTL;
        BDM_OFS_TIMER0_OPT: target = bank ? BDM_T_OPTION : BDM_T_TIMER0;
        BDM_OFS_PORTA: target = bank ? BDM_T_PORTA_DIR : BDM_T_PORTA;
        BDM_OFS_PORTB: target = bank ? BDM_T_PORTB_DIR : BDM_T_PORTB;
        BDM_OFS_PIR_PIE: target = bank ? BDM_T_PIE : BDM_T_PIR;
        BDM_OFS_PWRCTL: target = bank ? BDM_T_PWRCTL : BDM_T_NONE;
        BDM_OFS_EEPROM: target = bank ? BDM_T_EEPROM : BDM_T_NONE;
        BDM_OFS_CMP_VREF: target = bank ? BDM_T_VREF : BDM_T_CMP;
        default: target = BDM_T_NONE;
      endcase
    end
  end

endmodule

// File: tb/bdm_data_memory_assertions.sv
// checker: port relations of the banked data memory
// assumes binding to bdm_data_memory
`timescale 1ns/1ps
module bdm_chk
  import bdm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic large_variant,
  input wire logic [6:0] file_addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] pointer_word,
  input wire logic bank_select_bit,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rd_data
);
  // ----
  // sequences
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_ram_wr;
    wr_en && !rd_en && file_addr >= 7'h20 && (!bank_select_bit
      || file_addr >= 7'h70 || (large_variant && file_addr <= 7'h3F));
  endsequence
  sequence s_same_rd;
    rd_en && !wr_en && $stable(file_addr) && $stable(bank_select_bit);
  endsequence
  // ----
  // assertions
  // ----
  AST_RAM_READBACK: assert property (s_ram_wr ##1 s_same_rd
    |=> rd_data == $past(wr_data, 2)) else $error("ram readback wrong");
  AST_LOW_SFR: assert property ((rd_en || wr_en) && file_addr >= 7'h20
    |-> !sfr_rd && !sfr_wr) else $error("strobe above sfr area");
  AST_B1_EMPTY: assert property (rd_en && bank_select_bit && file_addr < 7'h70
    && (file_addr >= 7'h40 || (!large_variant && file_addr >= 7'h20))
    |=> rd_data == 8'h00) else $error("empty area read nonzero");
  AST_IND_ZERO: assert property (rd_en && file_addr == 7'h00
    && pointer_word[6:0] == 7'h00 |=> rd_data == 8'h00) else $error("self pointer read");
  AST_SFR_PATH: assert property (sfr_rd |=> rd_data == $past(sfr_rd_data))
    else $error("peripheral data lost");
  AST_IDLE_ZERO: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data held");
  AST_PTR_WR: assert property (wr_en && file_addr == 7'h04
    |=> pointer_word == $past(wr_data)) else $error("pointer not written");
  AST_STATUS_WR: assert property (wr_en && file_addr == 7'h03
    |=> ((pointer_word ^ pointer_word) | (($past(wr_data) >> 5) & 8'h01))
    == {7'h00, bank_select_bit}) else $error("bank select not written");
endmodule
bind bdm_data_memory bdm_chk u_bdm_chk (.clk, .resetn, .large_variant, .file_addr,
  .rd_en, .wr_en, .wr_data, .rd_data, .pointer_word, .bank_select_bit, .sfr_rd,
  .sfr_wr, .sfr_rd_data);

// File: tb/bdm_cpu_model.sv
// cpu datapath model: one file access per call
// assumes the caller sits on a falling edge
`timescale 1ns/1ps
module bdm_cpu_model (
  input wire logic clk,
  output logic [6:0] file_addr,
  output logic rd_en,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic status_flags_we,
  output logic [7:0] status_flags_in
);
  initial acc(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 8'h00);
  task automatic acc(input logic w, input logic r, input logic [6:0] a,
    input logic [7:0] d, input logic fw, input logic [7:0] fv);
    file_addr = a;
    rd_en = r;
    wr_en = w;
    wr_data = d;
    status_flags_we = fw;
    status_flags_in = fv;
    @(negedge clk);
  endtask
  // released lines show the inverse of the last value
  task automatic idle();
    acc(1'b0, 1'b0, ~file_addr, ~wr_data, 1'b0, ~status_flags_in);
  endtask
endmodule

// File: tb/tb_banked_data_memory_decoder.sv
// testbench: sweeps the map and checks read data in order
// assumes package, cpu model and checker compiled first
`timescale 1ns/1ps
module tb_banked_data_memory_decoder;
  import bdm_pkg::*;
  logic clk, resetn, large_variant, rd_en, wr_en, status_flags_we;
  logic bank_select_bit, sfr_rd, sfr_wr, rd_p, bank;
  logic [6:0] file_addr;
  logic [4:0] sfr_sel;
  logic [7:0] wr_data, rd_data, status_flags_in, status_word, pointer_word;
  logic [7:0] sfr_wr_data, sfr_rd_data, ptr, lf, ex;
  logic [7:0] mem [0:255];
  logic [7:0] q [$];
  int failures, checks;
  logic [6:0] so [9] = '{7'h01, 7'h02, 7'h05, 7'h06, 7'h0A, 7'h0B, 7'h0E, 7'h10, 7'h1F};
  bdm_target_t t0 [9] = '{BDM_T_TIMER0, BDM_T_PCL, BDM_T_PORTA, BDM_T_PORTB,
    BDM_T_PROGRAM_COUNTER_HIGH_LATCH, BDM_T_INTCTL, BDM_T_NONE, BDM_T_NONE, BDM_T_CMP};
  bdm_target_t t1 [9] = '{BDM_T_OPTION, BDM_T_PCL, BDM_T_PORTA_DIR, BDM_T_PORTB_DIR,
    BDM_T_PROGRAM_COUNTER_HIGH_LATCH, BDM_T_INTCTL, BDM_T_PWRCTL, BDM_T_EEPROM, BDM_T_VREF};
  logic [7:0] pr [7] = '{8'hA3, 8'hF7, 8'h77, 8'h2C, 8'h80, 8'h00, 8'hC5};
  bdm_data_memory u_bdm_data_memory (.clk, .resetn, .large_variant, .file_addr, .rd_en,
    .wr_en, .wr_data, .rd_data, .status_flags_we, .status_flags_in, .status_word,
    .pointer_word, .bank_select_bit, .sfr_sel, .sfr_rd, .sfr_wr, .sfr_wr_data, .sfr_rd_data);
  bdm_cpu_model u_bdm_cpu_model (.clk, .file_addr, .rd_en, .wr_en, .wr_data,
    .status_flags_we, .status_flags_in);
  // peripheral answers with its select code
  assign sfr_rd_data = sfr_rd ? {3'h5, sfr_sel} : {3'h2, ~sfr_sel};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int ph(input logic b, input logic [6:0] o);
    if (o < 7'h20 || (b && o < 7'h70 && !(large_variant && o < 7'h40))) return -1;
    return (b && o < 7'h70) ? 128 + o : o;
  endfunction
  function automatic logic [7:0] sv(input bdm_target_t t);
    return (t == BDM_T_NONE) ? 8'h00 : {3'h5, t};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic op(input logic w, input logic r, input logic [6:0] a,
    input logic [7:0] d, input logic [7:0] e);
    int p;
    p = (a == 7'h00) ? ph(ptr[7], ptr[6:0]) : ph(bank, a);
    if (w && p >= 0) mem[p] = d;
    if (r) q.push_back(p >= 0 ? mem[p] : e);
    if (w && a == 7'h03) bank = d[5];
    if (w && a == 7'h04) ptr = d;
    u_bdm_cpu_model.acc(w, r, a, d, 1'b0, 8'h00);
  endtask
  task automatic bnk(input logic b);
    op(1'b1, 1'b0, 7'h03, {2'b00, b, 5'h18}, 8'h00);
  endtask
  task test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // result monitor
  // ----
  always @(posedge clk) rd_p <= resetn && rd_en;
  always @(negedge clk) begin
    if (rd_p) begin
      ex = q.size() > 0 ? q.pop_front() : 8'hXX;
      chk(rd_data, ex);
    end else chk(rd_data, 8'h00);
  end
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    lf = 8'h13;
    failures = 0;
    checks = 0;
    for (int v = 0; v < 2; v++) begin
      resetn = 1'b0;
      large_variant = v[0];
      bank = 1'b0;
      ptr = 8'h00;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      chk(pointer_word, 8'h00);
      for (int b = 0; b < 2; b++) begin
        bnk(b[0]);
        for (int o = 32; o < 128; o++) begin
          op(1'b1, 1'b0, o[6:0], lf, 8'h00);
          op(1'b0, 1'b1, o[6:0], 8'h00, 8'h00);
          lf = nx(lf);
        end
      end
      for (int b = 0; b < 2; b++) begin
        bnk(b[0]);
        for (int o = 32; o < 128; o++) op(1'b0, 1'b1, o[6:0], 8'h00, 8'h00);
        foreach (so[i]) op(1'b0, 1'b1, so[i], 8'h00, sv(b ? t1[i] : t0[i]));
      end
      foreach (pr[i]) begin
        op(1'b1, 1'b0, 7'h04, pr[i], 8'h00);
        op(1'b0, 1'b1, 7'h04, 8'h00, pr[i]);
        op(1'b1, 1'b0, 7'h00, lf, 8'h00);
        op(1'b0, 1'b1, 7'h00, 8'h00, 8'h00);
        lf = nx(lf);
      end
      u_bdm_cpu_model.acc(1'b1, 1'b0, 7'h03, 8'h38, 1'b1, 8'h00);
      chk({7'h00, status_word[5]}, 8'h01);
      u_bdm_cpu_model.acc(1'b0, 1'b0, 7'h20, 8'h00, 1'b1, 8'h08);
      chk({7'h00, status_word[5]}, 8'h00);
      u_bdm_cpu_model.idle();
    end
    test_done();
  end
endmodule
